// ---- logic/wwdt_pkg.sv ----
// Package with register map, field layout, reset values and timing for the windowed watchdog.
package wwdt_pkg;

	// Register byte offsets on the AHB-Lite bus.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0C;
	localparam logic [7:0] OFS_CNT = 8'h10;

	// Timer widths and divide ratio.
	localparam int CNT_W = 12;
	localparam int PRE_W = 7;
	localparam logic [PRE_W-1:0] PRE_LAST = 7'h7F;

	// Clock rates: core clock and nominal slow clock emulated by an enable.
	localparam int CORE_HZ = 125_000_000;
	localparam int SLCK_HZ = 32_768;
	localparam int SLCK_DIV = CORE_HZ / SLCK_HZ;

	// Control word layout.
	localparam int CTRL_RESTART_BIT = 0;
	localparam int CTRL_KEY_LSB = 24;
	localparam logic [7:0] CTRL_KEY = 8'hA5;

	// Mode word layout.
	localparam int MODE_RELOAD_LSB = 0;
	localparam int MODE_FIEN_BIT = 12;
	localparam int MODE_RSTEN_BIT = 13;
	localparam int MODE_DIS_BIT = 15;
	localparam int MODE_DELTA_LSB = 16;
	localparam int MODE_DBGHLT_BIT = 28;
	localparam int MODE_IDLEHLT_BIT = 29;

	// Status and mask layout: bit 0 underflow, bit 1 window error.
	localparam int STAT_UNF_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam logic [1:0] MASK_RESET = 2'h3;

	// Decoded mode register.
	typedef struct packed {
		logic idle_halt_bit;
		logic debug_halt_bit;
		logic [CNT_W-1:0] window_delta_field;
		logic counting_disable_bit;
		logic fault_reset_enable;
		logic fault_interrupt_enable;
		logic [CNT_W-1:0] reload_value_field;
	} wwdt_mode_t;

	localparam wwdt_mode_t MODE_RESET = '{
		idle_halt_bit: 1'b0,
		debug_halt_bit: 1'b0,
		window_delta_field: 12'hFFF,
		counting_disable_bit: 1'b0,
		fault_reset_enable: 1'b1,
		fault_interrupt_enable: 1'b0,
		reload_value_field: 12'hFFF
	};

endpackage

// ---- logic/wwdt_top.sv ----
// Windowed watchdog timer with an AHB-Lite register slave.
`timescale 1ns/1ns
`default_nettype none

module wwdt_top #(
	parameter int SLCK_DIV = wwdt_pkg::SLCK_DIV,
	parameter logic [7:0] CTRL_KEY = wwdt_pkg::CTRL_KEY
) (
	// Clock and synchronous reset; rst is the processor reset.
	input wire logic core_clk,
	input wire logic rst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Processor state.
	input wire logic proc_debug,
	input wire logic proc_idle,
	// Fault line and interrupt.
	output logic wdt_fault,
	output logic wdt_irq
);

	// Bus address phase captured for the data phase.
	logic ap_wr_r;
	logic [7:0] ap_addr_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_word;

	// Timer state.
	logic [11:0] slck_cnt_r;
	logic [wwdt_pkg::PRE_W-1:0] pre_r;
	logic [wwdt_pkg::CNT_W-1:0] count_r;
	wwdt_pkg::wwdt_mode_t mode_r;
	logic mode_lock_r;
	logic unf_r;
	logic err_r;
	logic [1:0] mask_r;
	logic fault_r;
	logic irq_r;

	// Builds the mode record from a written word.
	function automatic wwdt_pkg::wwdt_mode_t mode_unpack(input logic [31:0] w);
		wwdt_pkg::wwdt_mode_t m;
		m.reload_value_field = w[wwdt_pkg::MODE_RELOAD_LSB +: wwdt_pkg::CNT_W];
		m.fault_interrupt_enable = w[wwdt_pkg::MODE_FIEN_BIT];
		m.fault_reset_enable = w[wwdt_pkg::MODE_RSTEN_BIT];
		m.counting_disable_bit = w[wwdt_pkg::MODE_DIS_BIT];
		m.window_delta_field = w[wwdt_pkg::MODE_DELTA_LSB +: wwdt_pkg::CNT_W];
		m.debug_halt_bit = w[wwdt_pkg::MODE_DBGHLT_BIT];
		m.idle_halt_bit = w[wwdt_pkg::MODE_IDLEHLT_BIT];
		return m;
	endfunction

	// Places the mode record back into a bus word.
	function automatic logic [31:0] mode_pack(input wwdt_pkg::wwdt_mode_t m);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[wwdt_pkg::MODE_RELOAD_LSB +: wwdt_pkg::CNT_W] = m.reload_value_field;
		w[wwdt_pkg::MODE_FIEN_BIT] = m.fault_interrupt_enable;
		w[wwdt_pkg::MODE_RSTEN_BIT] = m.fault_reset_enable;
		w[wwdt_pkg::MODE_DIS_BIT] = m.counting_disable_bit;
		w[wwdt_pkg::MODE_DELTA_LSB +: wwdt_pkg::CNT_W] = m.window_delta_field;
		w[wwdt_pkg::MODE_DBGHLT_BIT] = m.debug_halt_bit;
		w[wwdt_pkg::MODE_IDLEHLT_BIT] = m.idle_halt_bit;
		return w;
	endfunction

	// Address phase decode.
	wire ap_go = hsel & htrans[1] & hready;
	wire ap_is_rd = ap_go & ~hwrite;
	wire stat_rd = ap_is_rd & (haddr[7:0] == wwdt_pkg::OFS_STAT);

	// Data phase write strobes.
	wire wr_ctrl = ap_wr_r & (ap_addr_r == wwdt_pkg::OFS_CTRL);
	wire wr_mode_any = ap_wr_r & (ap_addr_r == wwdt_pkg::OFS_MODE);
	wire wr_stat = ap_wr_r & (ap_addr_r == wwdt_pkg::OFS_STAT);
	wire wr_mask = ap_wr_r & (ap_addr_r == wwdt_pkg::OFS_MASK);

	// A control write counts only with the key and the restart bit.
	// key check
	wire key_ok = hwdata[wwdt_pkg::CTRL_KEY_LSB +: 8] == CTRL_KEY;
	wire cr_restart = wr_ctrl & key_ok & hwdata[wwdt_pkg::CTRL_RESTART_BIT];

	// Only the first mode write after reset takes effect.
	// write once
	wire wr_mode = wr_mode_any & ~mode_lock_r;
	wire wwdt_pkg::wwdt_mode_t mode_new = mode_unpack(hwdata);

	// Window check; a delta at or above the reload value opens the window fully.
	// window off
	wire win_on = mode_r.window_delta_field < mode_r.reload_value_field;
	wire win_bad = cr_restart & win_on & (count_r > mode_r.window_delta_field);
	wire restart = cr_restart & ~win_bad;

	// Slow clock enable and the 128 prescaler.
	wire slck_tick = slck_cnt_r == 12'(SLCK_DIV - 1);
	wire halted = mode_r.counting_disable_bit | (proc_debug & mode_r.debug_halt_bit) |
		(proc_idle & mode_r.idle_halt_bit);
	wire wd_tick = slck_tick & ~halted & (pre_r == wwdt_pkg::PRE_LAST);
	wire underflow = wd_tick & (count_r == '0) & ~restart & ~wr_mode;
	wire reload = restart | wr_mode;

	// Status next values: a new event wins over a read or write-one clear.
	// read clears
	wire unf_nxt = underflow | (unf_r & ~stat_rd & ~(wr_stat & hwdata[wwdt_pkg::STAT_UNF_BIT]));
	wire err_nxt = win_bad | (err_r & ~stat_rd & ~(wr_stat & hwdata[wwdt_pkg::STAT_ERR_BIT]));
	wire fault_set = win_bad | (underflow & mode_r.fault_reset_enable);
	wire fault_nxt = fault_set | (fault_r & ~stat_rd);
	wire [1:0] mask_nxt = wr_mask ? hwdata[1:0] : mask_r;
	wire fien_nxt = wr_mode ? mode_new.fault_interrupt_enable : mode_r.fault_interrupt_enable;
	wire irq_nxt = fien_nxt & |({err_nxt, unf_nxt} & mask_nxt);

	// Read mux.
	always_comb begin
		unique case (haddr[7:0])
			wwdt_pkg::OFS_MODE: rd_word = mode_pack(mode_r);
			wwdt_pkg::OFS_STAT: rd_word = {30'h0, err_r, unf_r};
			wwdt_pkg::OFS_MASK: rd_word = {30'h0, mask_r};
			wwdt_pkg::OFS_CNT: rd_word = {20'h0, count_r};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Bus slave: no wait states, always OKAY, read data registered for the data phase.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ap_wr_r <= 1'b0;
			ap_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else begin
			ap_wr_r <= ap_go & hwrite;
			ap_addr_r <= haddr[7:0];
			hrdata_r <= ap_is_rd ? rd_word : 32'h0000_0000;
		end
	end

	// Slow clock divider from the core clock.
	always_ff @(posedge core_clk) begin
		if (rst || slck_tick) begin
			slck_cnt_r <= 12'h000;
		end else begin
			slck_cnt_r <= slck_cnt_r + 12'h001;
		end
	end

	// Prescaler; restarted by any reload, frozen while halted.
	// prescaler restart
	always_ff @(posedge core_clk) begin
		if (rst || reload) begin
			pre_r <= '0;
		end else if (slck_tick && !halted) begin
			pre_r <= pre_r + 7'h01;
		end
	end

	// Mode register, reset to a running watchdog.
	// reset defaults
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_r <= wwdt_pkg::MODE_RESET;
			mode_lock_r <= 1'b0;
		end else if (wr_mode) begin
			mode_r <= mode_new;
			mode_lock_r <= 1'b1;
		end
	end

	// Down counter; underflow reloads it for the next period.
	// down counter
	always_ff @(posedge core_clk) begin
		if (rst) begin
			count_r <= wwdt_pkg::MODE_RESET.reload_value_field;
		end else if (wr_mode) begin
			count_r <= mode_new.reload_value_field;
		end else if (restart || underflow) begin
			count_r <= mode_r.reload_value_field;
		end else if (wd_tick) begin
			count_r <= count_r - 12'h001;
		end
	end

	// Flags, mask, fault and interrupt.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			unf_r <= 1'b0;
			err_r <= 1'b0;
			mask_r <= wwdt_pkg::MASK_RESET;
			fault_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			unf_r <= unf_nxt;
			err_r <= err_nxt;
			mask_r <= mask_nxt;
			fault_r <= fault_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Outputs straight from flip-flops; ready and response are constants after reset.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;
	assign wdt_fault = fault_r;
	assign wdt_irq = irq_r;

	// Checks.
	property p_unf;
		@(posedge core_clk) disable iff (rst)
		underflow |=> unf_r && (count_r == mode_r.reload_value_field);
	endproperty
	a_unf: assert property (p_unf) else $error("underflow not flagged");

	property p_unf_fault;
		@(posedge core_clk) disable iff (rst)
		(underflow && mode_r.fault_reset_enable) |=> wdt_fault;
	endproperty
	a_unf_fault: assert property (p_unf_fault) else $error("fault missing on underflow");

	property p_restart;
		@(posedge core_clk) disable iff (rst)
		(restart && !wr_mode) |=> (count_r == $past(mode_r.reload_value_field)) && (pre_r == 7'h00);
	endproperty
	a_restart: assert property (p_restart) else $error("restart did not reload");

	property p_badkey;
		@(posedge core_clk) disable iff (rst)
		(wr_ctrl && !key_ok && !wd_tick && !underflow) |=> (count_r == $past(count_r)) && !$rose(err_r);
	endproperty
	a_badkey: assert property (p_badkey) else $error("unkeyed control write acted");

	property p_once;
		@(posedge core_clk) disable iff (rst)
		(mode_lock_r && wr_mode_any) |=> mode_r == $past(mode_r);
	endproperty
	a_once: assert property (p_once) else $error("second mode write accepted");

	property p_mode_rst;
		@(posedge core_clk) disable iff (rst)
		!mode_lock_r |-> mode_r == wwdt_pkg::MODE_RESET;
	endproperty
	a_mode_rst: assert property (p_mode_rst) else $error("mode reset value wrong");

	property p_mode_load;
		@(posedge core_clk) disable iff (rst)
		wr_mode |=> count_r == $past(mode_new.reload_value_field);
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode write did not reload");

	property p_win;
		@(posedge core_clk) disable iff (rst)
		win_bad |=> err_r && wdt_fault ##1 (err_r || !wdt_fault);
	endproperty
	a_win: assert property (p_win) else $error("window error missed");

	property p_win_off;
		@(posedge core_clk) disable iff (rst)
		(cr_restart && mode_r.window_delta_field >= mode_r.reload_value_field) |=>
		!$rose(err_r) && (count_r == $past(mode_r.reload_value_field));
	endproperty
	a_win_off: assert property (p_win_off) else $error("error with window off");

	property p_irq;
		@(posedge core_clk) disable iff (rst)
		(unf_r && mask_r[0] && mode_r.fault_interrupt_enable) |-> wdt_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	property p_halt;
		@(posedge core_clk) disable iff (rst)
		(halted && !reload) |=> count_r == $past(count_r);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted");

	property p_rdclr;
		@(posedge core_clk) disable iff (rst)
		(stat_rd && !underflow && !win_bad) |=> !unf_r && !err_r && !wdt_fault && !wdt_irq;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("status read did not clear");

	// Checker count of unhalted slow ticks since the last reload or decrement.
	// tick count
	logic [7:0] chk_ticks_r;
	always_ff @(posedge core_clk) begin
		if (rst || reload || wd_tick) begin
			chk_ticks_r <= 8'h00;
		end else if (slck_tick && !halted) begin
			chk_ticks_r <= chk_ticks_r + 8'h01;
		end
	end

	property p_rate;
		@(posedge core_clk) disable iff (rst)
		wd_tick |-> chk_ticks_r == 8'h7F;
	endproperty
	a_rate: assert property (p_rate) else $error("decrement not every 128 slow ticks");

	property p_count_down;
		@(posedge core_clk) disable iff (rst)
		(wd_tick && !reload && count_r != 12'h000) |=> count_r == $past(count_r) - 12'h001;
	endproperty
	a_count_down: assert property (p_count_down) else $error("counter did not step down");

	property p_disable;
		@(posedge core_clk) disable iff (rst)
		mode_r.counting_disable_bit |=> !$rose(unf_r);
	endproperty
	a_disable: assert property (p_disable) else $error("underflow while disabled");

	property p_reset_clear;
		@(posedge core_clk) disable iff (rst)
		$fell(rst) |-> !unf_r && !err_r && !wdt_fault && !wdt_irq && !mode_lock_r && (mask_r == wwdt_pkg::MASK_RESET);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left state behind");

	property p_fault_off;
		@(posedge core_clk) disable iff (rst)
		(underflow && !mode_r.fault_reset_enable && !win_bad && !fault_r) |=> !wdt_fault;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault without reset enable");

	property p_win_dis;
		@(posedge core_clk) disable iff (rst)
		(win_bad && mode_r.counting_disable_bit) |=> err_r && wdt_fault;
	endproperty
	a_win_dis: assert property (p_win_dis) else $error("window error lost while disabled");

	property p_irq_off;
		@(posedge core_clk) disable iff (rst)
		(!mode_r.fault_interrupt_enable && !wr_mode) |=> !wdt_irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt without enable");

	property p_stat_wr;
		@(posedge core_clk) disable iff (rst)
		(wr_stat && hwdata[wwdt_pkg::STAT_UNF_BIT] && !underflow) |=> !unf_r;
	endproperty
	a_stat_wr: assert property (p_stat_wr) else $error("write one did not clear");

	c_unf: cover property (@(posedge core_clk) disable iff (rst) underflow);
	c_restart: cover property (@(posedge core_clk) disable iff (rst) restart);
	c_win: cover property (@(posedge core_clk) disable iff (rst) win_bad);
	c_rdclr: cover property (@(posedge core_clk) disable iff (rst) unf_r ##1 stat_rd);
	c_halt: cover property (@(posedge core_clk) disable iff (rst) halted && proc_debug);

endmodule // wwdt_top

`default_nettype wire

// ---- verification/wwdt_rstc_model.sv ----
// Reset controller model that turns a watchdog fault into a processor reset.
`timescale 1ns/1ns
`default_nettype none
module wwdt_rstc_model (
	// Clock and reset requests.
	input wire logic core_clk,
	input wire logic por,
	input wire logic fault_en,
	input wire logic wdt_fault,
	// Reset to the processor and the watchdog.
	output logic rst
);
	logic [2:0] hold_r;
	always_ff @(posedge core_clk) begin
		if (por)
			hold_r <= 3'h0;
		else if (fault_en && wdt_fault && hold_r == 3'h0)
			hold_r <= 3'h4;
		else if (hold_r != 3'h0)
			hold_r <= hold_r - 3'h1;
	end
	// The pulse holds the watchdog in reset for four cycles.
	assign rst = por | (hold_r != 3'h0);
endmodule // wwdt_rstc_model
`default_nettype wire

// ---- verification/wwdt_top_test.sv ----
// Self-checking bench for the windowed watchdog.
`timescale 1ns/1ns
`default_nettype none
module wwdt_top_test;
	localparam int DIV = 4;
	localparam int STEP = 128 * DIV;
	localparam logic [31:0] GO = {wwdt_pkg::CTRL_KEY, 24'h00_0001};
	logic core_clk, rst, por, fault_en, hsel, hwrite, hreadyout, hresp;
	logic proc_debug, proc_idle, wdt_fault, wdt_irq;
	logic [31:0] haddr, hwdata, hrdata, rd, lfsr, w;
	logic [1:0] htrans;
	logic [11:0] rel;
	logic [7:0] a;
	int bad_count, samples_checked, k;

	wwdt_top #(.SLCK_DIV(DIV), .CTRL_KEY(wwdt_pkg::CTRL_KEY)) uut (.core_clk(core_clk), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
		.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .proc_debug(proc_debug),
		.proc_idle(proc_idle), .wdt_fault(wdt_fault), .wdt_irq(wdt_irq));
	wwdt_rstc_model rstc (.core_clk(core_clk), .por(por), .fault_en(fault_en), .wdt_fault(wdt_fault), .rst(rst));

	// Free-running 125 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// Pseudo-random source and expected mode word; f is idle, debug, disable, reset, interrupt.
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] mode_word(input logic [11:0] rl, input logic [11:0] dl, input logic [4:0] f);
		logic [31:0] m;
		m = 32'h0000_0000;
		m[wwdt_pkg::MODE_RELOAD_LSB +: 12] = rl;
		m[wwdt_pkg::MODE_DELTA_LSB +: 12] = dl;
		m[wwdt_pkg::MODE_FIEN_BIT] = f[0];
		m[wwdt_pkg::MODE_RSTEN_BIT] = f[1];
		m[wwdt_pkg::MODE_DIS_BIT] = f[2];
		m[wwdt_pkg::MODE_DBGHLT_BIT] = f[3];
		m[wwdt_pkg::MODE_IDLEHLT_BIT] = f[4];
		return m;
	endfunction

	// Comparison and verdict.
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task close_out;
		$display("checks %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One AHB-Lite single transfer; read data lands in rd.
	task bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, ad};
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task cycles(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task por_cycle;
		@(posedge core_clk);
		por <= 1'b1;
		cycles(12);
		por <= 1'b0;
	endtask
	// Waits for the fault line (sel 1) or the interrupt (sel 0).
	task wait_for(input logic sel, input int lim);
		k = 0;
		while (k < lim && (sel ? wdt_fault : wdt_irq) !== 1'b1) begin
			@(posedge core_clk);
			k++;
		end
	endtask

	// Watchdog: the tests need about 16000 cycles.
	initial begin
		#(8 * 60000);
		bad_count++;
		close_out();
	end

	// Main sequence.
	initial begin
		por = 1'b1;
		fault_en = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		proc_debug = 1'b0;
		proc_idle = 1'b0;
		bad_count = 0;
		samples_checked = 0;
		lfsr = 32'h97e5_cd49;
		cycles(12);
		por <= 1'b0;
		bus(0, wwdt_pkg::OFS_MODE, 0);
		chk(rd, mode_word(12'hFFF, 12'hFFF, 5'h02));
		bus(0, wwdt_pkg::OFS_MASK, 0);
		chk(rd, 32'h0000_0003);
		chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
		lfsr = lfsr_next(lfsr);
		a = 8'h14 + {2'h0, lfsr[5:2], 2'h0};
		bus(1, a, lfsr);
		bus(0, a, 0);
		chk(rd, 32'h0000_0000);
		cycles(600);
		bus(0, wwdt_pkg::OFS_CNT, 0);
		chk(rd, 32'h0000_0FFE);
		lfsr = lfsr_next(lfsr);
		w = {(lfsr[31:24] == wwdt_pkg::CTRL_KEY) ? 8'h00 : lfsr[31:24], 24'h00_0001};
		bus(1, wwdt_pkg::OFS_CTRL, w);
		bus(0, wwdt_pkg::OFS_CNT, 0);
		chk(rd, 32'h0000_0FFE);
		bus(1, wwdt_pkg::OFS_CTRL, GO);
		bus(0, wwdt_pkg::OFS_CNT, 0);
		chk(rd, 32'h0000_0FFF);
		bus(0, wwdt_pkg::OFS_STAT, 0);
		chk(rd, 32'h0000_0000);
		cycles(400);
		bus(0, wwdt_pkg::OFS_CNT, 0);
		chk(rd, 32'h0000_0FFF);
		por_cycle();
		lfsr = lfsr_next(lfsr);
		rel = 12'h006 + {10'h000, lfsr[1:0]};
		w = mode_word(rel, 12'h003, 5'h01);
		bus(1, wwdt_pkg::OFS_MODE, w);
		bus(1, wwdt_pkg::OFS_MODE, mode_word(12'h009, 12'h009, 5'h02));
		bus(0, wwdt_pkg::OFS_MODE, 0);
		chk(rd, w);
		bus(0, wwdt_pkg::OFS_CNT, 0);
		chk(rd, {20'h0_0000, rel});
		bus(0, wwdt_pkg::OFS_STAT, 0);
		bus(1, wwdt_pkg::OFS_MASK, 0);
		bus(1, wwdt_pkg::OFS_CTRL, GO);
		cycles(3);
		chk({30'h0, wdt_fault, wdt_irq}, 32'h0000_0002);
		bus(1, wwdt_pkg::OFS_MASK, 32'h0000_0003);
		cycles(3);
		chk({31'h0, wdt_irq}, 32'h0000_0001);
		bus(0, wwdt_pkg::OFS_STAT, 0);
		chk(rd, 32'h0000_0002);
		cycles(2);
		chk({30'h0, wdt_fault, wdt_irq}, 32'h0000_0000);
		wait_for(0, 12 * STEP);
		chk({30'h0, wdt_fault, wdt_irq}, 32'h0000_0001);
		bus(0, wwdt_pkg::OFS_STAT, 0);
		chk(rd, 32'h0000_0001);
		bus(0, wwdt_pkg::OFS_CNT, 0);
		chk(rd, {20'h0_0000, rel});
		wait_for(0, 12 * STEP);
		chk({31'h0, wdt_irq}, 32'h0000_0001);
		bus(1, wwdt_pkg::OFS_STAT, 32'h0000_0001);
		cycles(2);
		chk({30'h0, wdt_fault, wdt_irq}, 32'h0000_0000);
		bus(0, wwdt_pkg::OFS_STAT, 0);
		chk(rd, 32'h0000_0000);
		por_cycle();
		bus(1, wwdt_pkg::OFS_MODE, mode_word(12'h004, 12'hFFF, 5'h1A));
		proc_debug <= 1'b1;
		cycles(1100);
		bus(0, wwdt_pkg::OFS_CNT, 0);
		chk(rd, 32'h0000_0004);
		proc_debug <= 1'b0;
		proc_idle <= 1'b1;
		cycles(1100);
		bus(0, wwdt_pkg::OFS_CNT, 0);
		chk(rd, 32'h0000_0004);
		proc_idle <= 1'b0;
		fault_en <= 1'b1;
		wait_for(1, 7 * STEP);
		chk({31'h0, wdt_fault}, 32'h0000_0001);
		cycles(8);
		fault_en <= 1'b0;
		bus(0, wwdt_pkg::OFS_MODE, 0);
		chk(rd, mode_word(12'hFFF, 12'hFFF, 5'h02));
		bus(0, wwdt_pkg::OFS_STAT, 0);
		chk(rd, 32'h0000_0000);
		por_cycle();
		bus(1, wwdt_pkg::OFS_MODE, mode_word(12'h002, 12'h001, 5'h06));
		cycles(2000);
		bus(0, wwdt_pkg::OFS_CNT, 0);
		chk(rd, 32'h0000_0002);
		chk({31'h0, wdt_fault}, 32'h0000_0000);
		bus(1, wwdt_pkg::OFS_CTRL, GO);
		cycles(3);
		chk({31'h0, wdt_fault}, 32'h0000_0001);
		close_out();
	end
endmodule // wwdt_top_test
`default_nettype wire
